// >>> logic/ebg_glue.sv
// static controller sequencer with flash and card pin steering
//
// Function
// - card slot0 select timed as select four
// - read-not-write held through transfer, address stepped per page beat
// - flash steering only when flash assigned
// - flash lives in the select-three window
// - select three routes strobes to flash enables
// - flash enables drop outside select-three window
// - flash enables replace select six and seven pins
// - A23 picks io or memory, A22 register
// - A21 picks alternate or normal ide set
// - eight low selects, 26-bit address bus
// - 32-bit data bus for 8/16/32 devices
// - low wait input stretches current access
// - slow clock mode forces fixed waveforms
// - page read bursts up to 32 bytes
// - reset defaults suit 16-bit slow boot
// - selects and strobes active low
// - A23..A21 decode the card modes
// - io/ide use io strobes, memory memory strobes
`timescale 1ns/10ps
module ebg_glue
    import ebg_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    // access requests from the processor bus
    input  wire logic                req_i,
    input  wire logic [DATA_W-1:0]   req_addr_i,
    input  wire logic                req_write_i,
    input  wire logic [DATA_W-1:0]   req_wdata_i,
    input  wire logic [3:0]          req_be_i,
    input  wire logic [4:0]          req_beats_i,
    output logic                     busy_o,
    output logic                     done_o,
    output logic                     err_o,
    output logic [DATA_W-1:0]        rdata_o,
    output logic                     rdata_valid_o,
    // configuration and chip select assignment
    input  wire logic                cfg_load_i,
    input  wire logic [1:0]          cfg_width_i,
    input  wire logic                cfg_byte_write_i,
    input  wire logic                cfg_cs_ctrl_i,
    input  wire logic                cfg_slow_i,
    input  wire logic                cfg_page_i,
    input  wire logic [5:0]          cfg_setup_i,
    input  wire logic [5:0]          cfg_pulse_i,
    input  wire logic [5:0]          cfg_hold_i,
    input  wire logic                flash_assign_bit_i,
    input  wire logic                card_slot0_assign_bit_i,
    input  wire logic                card_slot1_assign_bit_i,
    // external memory pins
    input  wire logic                external_wait_low_i,
    output logic [CS_COUNT-1:0]      chip_select_lines_n_o,
    output logic                     read_strobe_low_o,
    output logic                     write_strobe_low_o,
    output logic [3:0]               byte_sel_n_o,
    output logic [ADDR_W-1:0]        addr_o,
    input  wire logic [DATA_W-1:0]   data_in_i,
    output logic [DATA_W-1:0]        data_out_o,
    output logic                     data_oe_o,
    // card slot pins
    output logic                     card_slot0_select_o,
    output logic                     card_slot1_select_o,
    output logic                     card_read_not_write_o,
    output logic                     card_low_byte_enable_o,
    output logic                     card_high_byte_enable_o,
    output logic                     card_io_read_strobe_o,
    output logic                     card_io_write_strobe_o,
    output logic                     card_mem_read_strobe_o,
    output logic                     card_mem_write_strobe_o
);
    // configuration registers
    logic [1:0]        width_ff;
    logic              bytewr_ff;
    logic              csctrl_ff;
    logic              slow_ff;
    logic              page_ff;
    logic [5:0]        setup_ff;
    logic [5:0]        pulse_ff;
    logic [5:0]        hold_ff;
    // access sequencer
    ebg_state_t        st_ff;
    ebg_state_t        nxt_st;
    logic [5:0]        cnt_ff;
    logic [5:0]        nxt_cnt;
    logic [DATA_W-1:0] addr_ff;
    logic [DATA_W-1:0] nxt_addr;
    logic [4:0]        beats_ff;
    logic [4:0]        nxt_beats;
    logic [2:0]        sel_ff;
    logic              wr_ff;
    logic [3:0]        be_ff;
    logic              beat_done;    // one data phase ends this cycle
    logic              take_ok;
    logic              take_bad;
    logic              wait_low_w;

    // external wait comes from the card or a slow device, so synchronise it
    ebg_sync3 #(.RST_VAL(1'b1)) u_wait_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (external_wait_low_i),
        .sync_o    (wait_low_w)
    );

    // request decode: which chip select window, and is it usable
    wire [3:0] req_win    = req_addr_i[CS_MSB:CS_LSB];
    wire       win_valid  = (req_win >= CS_FIRST_WIN) && (req_win <= CS_LAST_WIN);
    wire [2:0] req_sel    = 3'(req_win - CS_FIRST_WIN);
    // selects six and seven are gone while their pins carry flash enables
    wire       sel_lost   = flash_assign_bit_i && (req_sel == PIN_FLASH_RD || req_sel == PIN_FLASH_WR);
    wire       req_idle   = (st_ff == ST_IDLE);
    assign take_ok  = req_idle && req_i && win_valid && !sel_lost;
    assign take_bad = req_idle && req_i && !(win_valid && !sel_lost);

    // phase lengths: slow clock mode overrides the programmed values
    wire [5:0] setup_len = slow_ff ? SLOW_SETUP_CYC : setup_ff;
    wire [5:0] pulse_len = slow_ff ? SLOW_PULSE_CYC : pulse_ff;
    wire [5:0] hold_len  = slow_ff ? SLOW_HOLD_CYC  : hold_ff;
    wire       cnt_last  = (cnt_ff <= 6'h01);

    // page length limit in beats depends on bus width
    wire [4:0] page_last = (width_ff == W8)  ? PAGE_LAST_W8 :
                           (width_ff == W16) ? PAGE_LAST_W16 : PAGE_LAST_W32;
    wire [4:0] req_extra = (req_beats_i > page_last) ? page_last : req_beats_i;
    wire [DATA_W-1:0] addr_step = (width_ff == W8)  ? 32'h0000_0001 :
                                  (width_ff == W16) ? 32'h0000_0002 : 32'h0000_0004;

    assign beat_done = (st_ff == ST_PULSE) && wait_low_w && cnt_last;

    // next state of the access sequencer
    always_comb begin
        nxt_st    = st_ff;
        nxt_cnt   = cnt_ff;
        nxt_addr  = addr_ff;
        nxt_beats = beats_ff;
        case (st_ff)
            ST_IDLE: begin
                if (take_ok) begin
                    nxt_st    = ST_SETUP;
                    nxt_cnt   = setup_len;
                    nxt_addr  = req_addr_i;
                    // page bursts are reads only
                    nxt_beats = (page_ff && !req_write_i) ? req_extra : 5'h00;
                end
            end
            ST_SETUP: begin
                if (cnt_last) begin
                    nxt_st  = ST_PULSE;
                    nxt_cnt = pulse_len;
                end else begin
                    nxt_cnt = cnt_ff - 6'h01;
                end
            end
            ST_PULSE: begin
                // a low wait freezes the pulse counter
                if (!wait_low_w) begin
                    nxt_cnt = cnt_ff;
                end else if (cnt_last && beats_ff != 5'h00) begin
                    nxt_cnt   = pulse_len;
                    nxt_beats = beats_ff - 5'h01;
                    nxt_addr  = addr_ff + addr_step;
                end else if (cnt_last) begin
                    nxt_st  = ST_HOLD;
                    nxt_cnt = hold_len;
                end else begin
                    nxt_cnt = cnt_ff - 6'h01;
                end
            end
            ST_HOLD: begin
                if (cnt_last) begin
                    nxt_st = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 6'h01;
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_ff    <= ST_IDLE;
            cnt_ff   <= 6'h00;
            addr_ff  <= 32'h0000_0000;
            beats_ff <= 5'h00;
        end else begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            addr_ff  <= nxt_addr;
            beats_ff <= nxt_beats;
        end
    end

    // request attributes, captured once and held for the whole transfer
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sel_ff     <= 3'h0;
            wr_ff      <= 1'b0;
            be_ff      <= 4'h0;
            data_out_o <= 32'h0000_0000;
        end else if (take_ok) begin
            sel_ff     <= req_sel;
            wr_ff      <= req_write_i;
            be_ff      <= req_be_i;
            data_out_o <= req_wdata_i;
        end
    end

    // configuration: defaults allow a 16-bit boot at slow clock
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            width_ff  <= RST_WIDTH;
            bytewr_ff <= RST_BYTE_WR;
            csctrl_ff <= RST_CS_CTRL;
            slow_ff   <= RST_SLOW;
            page_ff   <= 1'b0;
            setup_ff  <= RST_PHASE;
            pulse_ff  <= RST_PHASE;
            hold_ff   <= RST_PHASE;
        end else if (cfg_load_i && req_idle) begin
            // loading mid-transfer would bend the waveform, so only when idle
            width_ff  <= cfg_width_i;
            bytewr_ff <= cfg_byte_write_i;
            csctrl_ff <= cfg_cs_ctrl_i;
            slow_ff   <= cfg_slow_i;
            page_ff   <= cfg_page_i;
            setup_ff  <= cfg_setup_i;
            pulse_ff  <= cfg_pulse_i;
            hold_ff   <= cfg_hold_i;
        end
    end

    // next pin values, from the next sequencer state and the request or held attributes
    wire       act_nxt   = (nxt_st != ST_IDLE);
    wire       pulse_nxt = (nxt_st == ST_PULSE);
    wire       hold_nxt  = (st_ff == ST_IDLE) ? req_write_i : wr_ff;
    wire [2:0] sel_nxt   = (st_ff == ST_IDLE) ? req_sel : sel_ff;
    wire [3:0] be_nxt    = (st_ff == ST_IDLE) ? req_be_i : be_ff;
    // chip-select-controlled mode stretches strobes over the whole select
    wire       strb_nxt  = csctrl_ff ? act_nxt : pulse_nxt;
    wire       rd_nxt    = strb_nxt && !hold_nxt;
    wire       wr_nxt    = strb_nxt && hold_nxt;
    wire [CS_COUNT-1:0] cs_n_nxt = act_nxt ? ~(8'h01 << sel_nxt) : 8'hff;

    // flash steering: select three, flash assigned, address in its window
    wire       fl_hit    = flash_assign_bit_i && (sel_nxt == FLASH_CS)
                           && (nxt_addr[CS_MSB:CS_LSB] == FLASH_WIN);
    wire       fl_re_n   = !(fl_hit && rd_nxt);
    wire       fl_we_n   = !(fl_hit && wr_nxt);
    wire       pin6_n    = flash_assign_bit_i ? fl_re_n : cs_n_nxt[PIN_FLASH_RD];
    wire       pin7_n    = flash_assign_bit_i ? fl_we_n : cs_n_nxt[PIN_FLASH_WR];
    wire [CS_COUNT-1:0] pins_nxt = {pin7_n, pin6_n, cs_n_nxt[5:0]};

    // card steering: mode from A23..A21 of the transfer address
    wire       c0_hit    = card_slot0_assign_bit_i && (sel_nxt == CARD0_CS) && act_nxt;
    wire       c1_hit    = card_slot1_assign_bit_i && (sel_nxt == CARD1_CS) && act_nxt;
    wire       card_hit  = c0_hit || c1_hit;
    wire [2:0] card_mode = nxt_addr[MODE_MSB:MODE_LSB];
    wire       io_mode   = (card_mode == MODE_IO) || (card_mode == MODE_IDE)
                           || (card_mode == MODE_ALT_IDE);
    wire       mem_mode  = (card_mode == MODE_ATTR) || (card_mode == MODE_COMMON);
    wire       alt_ide   = (card_mode == MODE_ALT_IDE);
    // byte enables: alternate ide uses the high enable, 8-bit the low one
    wire       ce_lo_nxt = !card_hit ? 1'b1 : alt_ide ? 1'b1
                           : (width_ff == W8) ? 1'b0 : !be_nxt[0];
    wire       ce_hi_nxt = !card_hit ? 1'b1 : alt_ide ? 1'b0
                           : (width_ff == W8) ? 1'b1 : !be_nxt[1];

    // byte lanes: write lines in byte-write mode, select lines otherwise
    wire [3:0] bsel_nxt  = bytewr_ff ? ~(be_nxt & {4{wr_nxt}})
                         : (act_nxt ? ~be_nxt : 4'hf);

    // pin registers; flash enables share the edge of the strobes they copy
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            chip_select_lines_n_o <= 8'hff;
            read_strobe_low_o     <= 1'b1;
            write_strobe_low_o    <= 1'b1;
            byte_sel_n_o          <= 4'hf;
            data_oe_o             <= 1'b0;
        end else begin
            chip_select_lines_n_o <= pins_nxt;
            read_strobe_low_o     <= !rd_nxt;
            write_strobe_low_o    <= !(wr_nxt && !bytewr_ff);
            byte_sel_n_o          <= bsel_nxt;
            data_oe_o             <= act_nxt && hold_nxt;
        end
    end

    // card pin registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            card_slot0_select_o     <= 1'b1;
            card_slot1_select_o     <= 1'b1;
            card_read_not_write_o   <= 1'b1;
            card_low_byte_enable_o  <= 1'b1;
            card_high_byte_enable_o <= 1'b1;
            card_io_read_strobe_o   <= 1'b1;
            card_io_write_strobe_o  <= 1'b1;
            card_mem_read_strobe_o  <= 1'b1;
            card_mem_write_strobe_o <= 1'b1;
        end else begin
            card_slot0_select_o     <= card_slot0_assign_bit_i ? cs_n_nxt[CARD0_CS] : 1'b1;
            card_slot1_select_o     <= card_slot1_assign_bit_i ? cs_n_nxt[CARD1_CS] : 1'b1;
            card_read_not_write_o   <= act_nxt ? !hold_nxt : card_read_not_write_o;
            card_low_byte_enable_o  <= ce_lo_nxt;
            card_high_byte_enable_o <= ce_hi_nxt;
            card_io_read_strobe_o   <= !(card_hit && io_mode && rd_nxt);
            card_io_write_strobe_o  <= !(card_hit && io_mode && wr_nxt);
            card_mem_read_strobe_o  <= !(card_hit && mem_mode && rd_nxt);
            card_mem_write_strobe_o <= !(card_hit && mem_mode && wr_nxt);
        end
    end

    // bus answers: data per beat, done when the hold phase ends
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            busy_o        <= 1'b0;
            done_o        <= 1'b0;
            err_o         <= 1'b0;
            rdata_o       <= 32'h0000_0000;
            rdata_valid_o <= 1'b0;
        end else begin
            busy_o        <= act_nxt;
            done_o        <= take_bad || ((st_ff == ST_HOLD) && cnt_last);
            err_o         <= take_bad;
            rdata_valid_o <= beat_done && !wr_ff;
            rdata_o       <= (beat_done && !wr_ff) ? data_in_i : rdata_o;
        end
    end

    // the address pins simply show the transfer address, stepped on each page beat
    assign addr_o = addr_ff[ADDR_W-1:0];

    // card select four pin and slot0 select move together
    chk_card_cs_same: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $past(card_slot0_assign_bit_i) |->
            card_slot0_select_o == chip_select_lines_n_o[CARD0_CS])
        else $error("slot0 select differs from select four");

    chk_rnw_stable: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        busy_o && $past(busy_o) |-> $stable(card_read_not_write_o))
        else $error("card direction changed inside a transfer");

    chk_flash_window: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $past(flash_assign_bit_i) && !chip_select_lines_n_o[PIN_FLASH_RD] |->
            busy_o && addr_ff[CS_MSB:CS_LSB] == FLASH_WIN && !read_strobe_low_o)
        else $error("flash read enable low outside its window");

    chk_flash_follow: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $past(flash_assign_bit_i) && busy_o && sel_ff == FLASH_CS |->
            chip_select_lines_n_o[PIN_FLASH_WR] == write_strobe_low_o
            || bytewr_ff)
        else $error("flash write enable does not track write strobe");

    chk_wait_hold: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        st_ff == ST_PULSE && !wait_low_w |=> st_ff == ST_PULSE && $stable(cnt_ff))
        else $error("pulse advanced while wait asserted");

    chk_slow_setup: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        st_ff == ST_SETUP && $past(st_ff) == ST_IDLE && slow_ff |->
            cnt_ff == SLOW_SETUP_CYC)
        else $error("slow mode did not force setup length");

    chk_reset_cfg: assert property (
        @(posedge clk_i)
        !reset_n_i |=> width_ff == RST_WIDTH && slow_ff && csctrl_ff && !bytewr_ff)
        else $error("controller configuration not at boot defaults");

    chk_card_io_mem: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !card_io_read_strobe_o || !card_io_write_strobe_o |->
            card_mem_read_strobe_o && card_mem_write_strobe_o)
        else $error("card io and memory strobes active together");

    chk_cs_onehot: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $onehot0(~chip_select_lines_n_o[5:0]) && (busy_o || &chip_select_lines_n_o[5:0]))
        else $error("more than one select low or select without access");
endmodule

// >>> logic/ebg_pkg.sv
// shared constants and types for the external bus glue block
package ebg_pkg;
    // clock rate and fixed slow-clock waveform lengths
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOW_SETUP_NS = 30;
    localparam int SLOW_PULSE_NS = 60;
    localparam int SLOW_HOLD_NS  = 30;
    localparam logic [5:0] SLOW_SETUP_CYC = 6'((SLOW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] SLOW_PULSE_CYC = 6'((SLOW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] SLOW_HOLD_CYC  = 6'((SLOW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // bus geometry
    localparam int CS_COUNT = 8;
    localparam int ADDR_W   = 26;
    localparam int DATA_W   = 32;
    // chip select windows: select n lives at base (n+1) << 28
    localparam int CS_MSB = 31;
    localparam int CS_LSB = 28;
    localparam logic [3:0] CS_FIRST_WIN = 4'h1;
    localparam logic [3:0] CS_LAST_WIN  = 4'h8;
    localparam logic [3:0] FLASH_WIN    = 4'h4;
    localparam logic [2:0] FLASH_CS     = 3'h3;
    localparam logic [2:0] CARD0_CS     = 3'h4;
    localparam logic [2:0] CARD1_CS     = 3'h5;
    localparam logic [2:0] PIN_FLASH_RD = 3'h6;
    localparam logic [2:0] PIN_FLASH_WR = 3'h7;
    // card mode field and its codes
    localparam int MODE_MSB = 23;
    localparam int MODE_LSB = 21;
    localparam logic [2:0] MODE_ATTR    = 3'h0;
    localparam logic [2:0] MODE_COMMON  = 3'h2;
    localparam logic [2:0] MODE_IO      = 3'h4;
    localparam logic [2:0] MODE_IDE     = 3'h6;
    localparam logic [2:0] MODE_ALT_IDE = 3'h7;
    // data bus width codes and page limits
    localparam logic [1:0] W8  = 2'h0;
    localparam logic [1:0] W16 = 2'h1;
    localparam logic [1:0] W32 = 2'h2;
    localparam logic [4:0] PAGE_LAST_W8  = 5'h1f;
    localparam logic [4:0] PAGE_LAST_W16 = 5'h0f;
    localparam logic [4:0] PAGE_LAST_W32 = 5'h07;
    // reset defaults of the controller configuration
    localparam logic [1:0] RST_WIDTH   = W16;
    localparam logic       RST_BYTE_WR = 1'b0;
    localparam logic       RST_CS_CTRL = 1'b1;
    localparam logic       RST_SLOW    = 1'b1;
    localparam logic [5:0] RST_PHASE   = 6'h01;
    // access sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} ebg_state_t;
endpackage

// >>> logic/ebg_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ebg_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic s1_ff;  // metastability catcher, read only by s2
    logic s2_ff;
    logic s3_ff;
    logic out_ff;

    // a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s1_ff  <= RST_VAL;
            s2_ff  <= RST_VAL;
            s3_ff  <= RST_VAL;
            out_ff <= RST_VAL;
        end else begin
            s1_ff  <= async_i;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= (s2_ff == s3_ff) ? s3_ff : out_ff;
        end
    end

    assign sync_o = out_ff;
endmodule

// >>> dv/ebg_mem_model.sv
// far-side memory, flash and card model: read data and wait requests
`timescale 1ns/10ps
module ebg_mem_model
    import ebg_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              read_strobe_low_i,
    input  wire logic              write_strobe_low_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [3:0]        stall_cycles_i,
    output logic [DATA_W-1:0]      data_o,
    output logic                   wait_low_o
);
    logic [DATA_W-1:0] last_ff   = '0;   // last value put on the data lines
    logic [3:0]        stall_ff  = '0;   // wait cycles still to hold
    logic              strobe_ff = 1'b0; // a strobe was low last cycle
    wire               act = !read_strobe_low_i || !write_strobe_low_i;
    // flash chip enable sits on a spare pin kept low, so reads answer at once
    // released lines show the inverse so a stale value never passes
    assign data_o     = !read_strobe_low_i ? {6'h0, addr_i} : ~last_ff;
    assign wait_low_o = (stall_ff == 4'h0); // pull-up when not stalling
    // a stall starts on the falling strobe, as a slow card would
    always_ff @(posedge clk_i) begin
        strobe_ff <= act;
        if (act && !strobe_ff) stall_ff <= stall_cycles_i;
        else if (stall_ff != 4'h0) stall_ff <= stall_ff - 4'h1;
        if (!read_strobe_low_i) last_ff <= data_o;
    end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the external bus glue block
`timescale 1ns/10ps
module tb_top;
    import ebg_pkg::*;
    logic clk_i = 0, reset_n_i = 0, req_i = 0, req_write_i = 0, cfg_load_i = 0;
    logic [31:0] req_addr_i = '0, req_wdata_i = '0, cur_addr = '0;
    logic [1:0] cfg_width_i = W16;
    logic cfg_cs_ctrl_i = 1, cfg_slow_i = 1, cfg_page_i = 0, cur_wr = 0, sel_seen = 0;
    logic [5:0] cfg_setup_i = 6'h1, cfg_pulse_i = 6'h1, cfg_hold_i = 6'h1;
    logic flash_assign_bit_i = 0, card_slot0_assign_bit_i = 0, card_slot1_assign_bit_i = 0;
    logic [3:0] stall = '0;
    logic [4:0] beats = '0; // extra page beats asked for
    logic busy_o, done_o, err_o, rdata_valid_o, read_strobe_low_o, write_strobe_low_o;
    logic external_wait_low_i, data_oe_o, card_read_not_write_o;
    logic [31:0] rdata_o, data_in_i, data_out_o;
    logic [7:0] chip_select_lines_n_o;
    logic [3:0] byte_sel_n_o;
    logic [ADDR_W-1:0] addr_o;
    logic card_slot0_select_o, card_slot1_select_o, card_low_byte_enable_o;
    logic card_high_byte_enable_o, card_io_read_strobe_o, card_io_write_strobe_o;
    logic card_mem_read_strobe_o, card_mem_write_strobe_o;
    int miscompares = 0, check_count = 0, cycles = 0, n, v, xb = 0;
    wire [2:0] cs_idx = 3'(cur_addr[31:28] - 4'h1); // select of the current access
    wire in_flash = flash_assign_bit_i && cur_addr[31:28] == FLASH_WIN;
    wire in_card = card_slot0_assign_bit_i && cur_addr[31:28] == 4'h5;
    wire rd = read_strobe_low_o, wr = write_strobe_low_o;
    ebg_glue ebg_glue_i (.clk_i, .reset_n_i, .req_i, .req_addr_i, .req_write_i, .req_wdata_i,
        .req_be_i(4'hf), .req_beats_i(beats), .busy_o, .done_o, .err_o, .rdata_o, .rdata_valid_o,
        .cfg_load_i, .cfg_width_i, .cfg_byte_write_i(1'b0), .cfg_cs_ctrl_i, .cfg_slow_i,
        .cfg_page_i, .cfg_setup_i, .cfg_pulse_i, .cfg_hold_i, .flash_assign_bit_i,
        .card_slot0_assign_bit_i, .card_slot1_assign_bit_i, .external_wait_low_i,
        .chip_select_lines_n_o, .read_strobe_low_o, .write_strobe_low_o, .byte_sel_n_o,
        .addr_o, .data_in_i, .data_out_o, .data_oe_o, .card_slot0_select_o,
        .card_slot1_select_o, .card_read_not_write_o, .card_low_byte_enable_o,
        .card_high_byte_enable_o, .card_io_read_strobe_o, .card_io_write_strobe_o,
        .card_mem_read_strobe_o, .card_mem_write_strobe_o);
    ebg_mem_model ebg_mem_model_i (.clk_i, .read_strobe_low_i(read_strobe_low_o),
        .write_strobe_low_i(write_strobe_low_o), .addr_i(addr_o), .stall_cycles_i(stall),
        .data_o(data_in_i), .wait_low_o(external_wait_low_i));
    always #5 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one request, held only for the take edge; n counts cycles to done
    task automatic acc(input logic [31:0] a, input logic w, input logic e);
        @(negedge clk_i);
        cur_addr = a; cur_wr = w; sel_seen = 0; req_addr_i = a; req_write_i = w;
        req_wdata_i = ~a; req_i = 1; n = 0; v = 0;
        do begin @(negedge clk_i); n++; req_i = 0; end while (done_o !== 1'b1 && n < 300);
        chk({done_o, err_o}, {1'b1, e});
        chk(32'(sel_seen), 32'(!e));
        chk(v, (w || e) ? 0 : xb + 1);
    endtask
    // pin relations watched on every cycle of an access
    always @(negedge clk_i) if (busy_o === 1'b1) begin
        if (chip_select_lines_n_o[cs_idx] === 1'b0) sel_seen = 1;
        chk({card_slot1_select_o, card_slot0_select_o, chip_select_lines_n_o[4]},
            {1'b1, !in_card, cs_idx != 3'h4});
        chk({data_oe_o, byte_sel_n_o}, {cur_wr, 4'h0});
        if (cur_wr) chk(data_out_o, ~cur_addr);
        // each read beat carries the model's echo of its own address
        if (rdata_valid_o === 1'b1) begin
            chk(rdata_o, {6'h0, cur_addr[25:0] + 26'(2 * v)});
            v++;
        end
        chk({card_high_byte_enable_o, card_low_byte_enable_o},
            !in_card ? 2'b11 : (cur_addr[23:21] == MODE_ALT_IDE) ? 2'b01 : 2'b00);
        if (flash_assign_bit_i) chk(32'(chip_select_lines_n_o[7:6]), in_flash ? {wr, rd} : 2'b11);
        else if (cs_idx < 3'h6) chk(32'(chip_select_lines_n_o[7:6]), 32'h3);
        if (in_card) begin
            chk({card_read_not_write_o, addr_o}, {~cur_wr, cur_addr[25:0]});
            chk({card_io_read_strobe_o, card_io_write_strobe_o, card_mem_read_strobe_o,
                card_mem_write_strobe_o}, cur_addr[23] ? {rd, wr, 2'b11} : {2'b11, rd, wr});
        end
    end
    // hang guard
    always @(posedge clk_i) if (++cycles > 5000) begin miscompares++; end_of_test(); end
    initial begin
        repeat (6) @(negedge clk_i);
        reset_n_i = 1;
        @(negedge clk_i);
        chk({busy_o, chip_select_lines_n_o, rd, wr, card_read_not_write_o}, 32'h7ff);
        chk(32'(addr_o), 32'h0);
        acc(32'h1000_0000, 0, 0);
        chk(n, 32'(SLOW_SETUP_CYC + SLOW_PULSE_CYC + SLOW_HOLD_CYC) + 1);
        stall = 4'h8;
        acc(32'h1000_0000, 0, 0);
        chk(n, 32'(SLOW_SETUP_CYC + SLOW_PULSE_CYC + SLOW_HOLD_CYC) + 32'(stall) + 1);
        stall = 4'h0;
        $display("slow boot and wait test done");
        @(negedge clk_i) begin cfg_slow_i = 0; cfg_cs_ctrl_i = 0; cfg_load_i = 1; end
        @(negedge clk_i) cfg_load_i = 0;
        acc(32'h2000_0000, 0, 0);
        chk(n, 32'h4);
        flash_assign_bit_i = 1;
        for (int i = 0; i < 4; i++) acc(32'h4000_0000 | (i << 21), i[0], 0);
        acc(32'h5000_0000, 0, 0);
        acc(32'h7000_0000, 0, 1);
        acc(32'h8000_0000, 1, 1);
        acc(32'h9000_0000, 0, 1);
        flash_assign_bit_i = 0;
        acc(32'h7000_0000, 0, 0);
        acc(32'h4000_0000, 1, 0);
        $display("flash steering test done");
        card_slot0_assign_bit_i = 1;
        // each card mode once as a read and once as a write
        for (int k = 0; k < 10; k++)
            acc(32'h5000_0000 | ({3'h0, 3'h2, 3'h4, 3'h6, 3'h7} >> (3 * (k / 2)) & 7) << 21,
                k[0], 0);
        card_slot0_assign_bit_i = 0;
        acc(32'h5000_0000, 0, 0);
        $display("card mode test done");
        // page read asks for more beats than a 32-byte page holds, so it is clamped
        @(negedge clk_i) begin cfg_page_i = 1; cfg_load_i = 1; end
        @(negedge clk_i) cfg_load_i = 0;
        beats = 5'h14;
        xb = PAGE_LAST_W16;
        acc(32'h1000_0000, 0, 0);
        chk(n, 32'(PAGE_LAST_W16) + 4);
        $display("page burst test done");
        end_of_test();
    end
endmodule
